// ---- bench/stby_props.sv ----
// Checker for the standby link: mode moves, oscillator enable and wait length.
// Assumes it sits beside the link and gets the device's STAB_EXP_CUT.
`timescale 1ns/1ps
`default_nettype none

module stby_props
    import stby_pkg::*;
#(
    parameter int STAB_EXP_CUT = 0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Requests and levels from the controller
    input wire logic halt_req,
    input wire logic stop_req,
    input wire logic irq,
    input wire logic serial_rx_req,
    input wire logic adc_trig,
    input wire logic cpu_free_wake_mode_done,
    input wire logic cpu_free_wake_mode_en,
    input wire logic x1_cpu_sel,
    input wire logic x1_tick,
    // Device answers
    input wire logic hsosc_en,
    input wire stby_state_t mode
);
    // Shortest selectable wait, in crystal ticks
    localparam int MIN_TICKS = 2 ** (8 - STAB_EXP_CUT);
    logic [15:0] n_tick_ff;
    logic snz_ok;

    assign snz_ok = cpu_free_wake_mode_en && !x1_cpu_sel && (serial_rx_req || adc_trig);

    // Ticks seen during the current wait only
    always_ff @(posedge ref_clk) begin
        if (sys_rst || mode != ST_WAIT) begin
            n_tick_ff <= 16'h0000;
        end else if (x1_tick) begin
            n_tick_ff <= n_tick_ff + 16'h0001;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // ************************************************
    // Mode transitions
    // ************************************************
    halt_entry_a: assert property (mode == ST_RUN && halt_req && !stop_req |=> mode == ST_HALT && hsosc_en)
        else $error("halt not entered with oscillator kept");
    halt_hold_a: assert property (mode == ST_HALT && !irq |=> mode == ST_HALT)
        else $error("halt left without wake");
    stop_entry_a: assert property (mode == ST_RUN && stop_req |=> mode == ST_STOP && !hsosc_en)
        else $error("stop not entered with oscillator off");
    stop_hold_a: assert property (mode == ST_STOP && !irq && !snz_ok |=> mode == ST_STOP)
        else $error("stop left without allowed wake");
    stop_wake_a: assert property (mode == ST_STOP && irq |=> mode == ($past(x1_cpu_sel) ? ST_WAIT : ST_RUN))
        else $error("stop wake went to wrong mode");
    halt_wake_a: assert property (mode == ST_HALT && irq |=> mode == ST_RUN)
        else $error("halt wake not immediate");
    cpu_free_wake_mode_wake_a: assert property (mode == ST_STOP && !irq && snz_ok |=> mode == ST_CPU_FREE_WAKE_MODE)
        else $error("cpu_free_wake_mode trigger not taken");
    cpu_free_wake_mode_exit_a: assert property (mode == ST_CPU_FREE_WAKE_MODE && (irq || cpu_free_wake_mode_done) |=>
        mode == ($past(irq) ? ST_RUN : ST_STOP))
        else $error("cpu_free_wake_mode left to wrong mode");

    // ************************************************
    // Stabilization wait
    // ************************************************
    wait_osc_a: assert property (mode == ST_WAIT |-> hsosc_en)
        else $error("oscillator off during wait");
    wait_min_a: assert property (mode != ST_WAIT ##1 mode == ST_WAIT |-> (mode == ST_WAIT) [*8])
        else $error("wait ended too early");
    wait_len_a: assert property (mode == ST_WAIT ##1 mode != ST_WAIT |-> mode == ST_RUN && n_tick_ff >= MIN_TICKS)
        else $error("wait ended before shortest threshold");

    halt_seen_c: cover property (mode == ST_RUN ##1 mode == ST_HALT);
    wait_done_c: cover property (mode == ST_WAIT ##1 mode == ST_RUN);
    cpu_free_wake_mode_seen_c: cover property (mode == ST_STOP ##1 mode == ST_CPU_FREE_WAKE_MODE);
endmodule : stby_props

`default_nettype wire

// ---- bench/tb_standby_and_osc_stabilization.sv ----
// Bench joining controller and device over the link, driving the software port and wake pins.
// Assumes a shortened count (CUT) and the register offsets of stby_regs.svh.
`include "stby_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_standby_and_osc_stabilization;
    import stby_pkg::*;

    localparam int CUT = 6;
    localparam logic [39:0] EXPS = `STAB_EXP_TABLE;
    `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
        $display("unexpected at %0t: got %h want %h", $time, g, e); end end

    typedef struct packed {logic wr; addr_t a; byte_t d;} row_t;
    // Reads carry the expected byte, writes the data
    row_t rows [8] = '{
        '{1'b0, `CNT_STATUS_ADDR, 8'h00}, '{1'b0, `TIME_SEL_ADDR, 8'h07}, '{1'b0, `CFG_ADDR, 8'h01},
        '{1'b0, 20'h12345, 8'h00}, '{1'b1, `TIME_SEL_ADDR, 8'hFB}, '{1'b0, `TIME_SEL_ADDR, 8'h03},
        '{1'b1, `CNT_STATUS_ADDR, 8'hFF}, '{1'b0, `CNT_STATUS_ADDR, 8'h00}};

    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    addr_t sw_addr = 20'h00000;
    byte_t sw_wdata = 8'h00;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    byte_t sw_rdata;
    logic irq_pin = 1'b0;
    logic rx_pin = 1'b0;
    logic adc_pin = 1'b0;
    logic done_pin = 1'b0;
    logic periph_stop, cpu_clk_en, hoco_en, loco_en, cpu_free_wake_mode_run, port_hold;
    int n_mismatch = 0;
    int samples_checked = 0;
    int ticks = 0;
    int n;
    int i;
    byte_t got;

    stby_if link ();
    stby_ctl stby_ctl_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq_pin(irq_pin), .serial_rx_pin(rx_pin),
        .adc_trig_pin(adc_pin), .cpu_free_wake_mode_done_pin(done_pin), .periph_stop(periph_stop), .link(link));
    stby_dev #(.STAB_EXP_CUT(CUT)) stby_dev_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
        .cpu_clk_en(cpu_clk_en), .hoco_en(hoco_en), .loco_en(loco_en), .cpu_free_wake_mode_run(cpu_free_wake_mode_run),
        .port_hold(port_hold));
    stby_props #(.STAB_EXP_CUT(CUT)) stby_props_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .halt_req(link.halt_req), .stop_req(link.stop_req), .irq(link.irq), .serial_rx_req(link.serial_rx_req),
        .adc_trig(link.adc_trig), .cpu_free_wake_mode_done(link.cpu_free_wake_mode_done), .cpu_free_wake_mode_en(link.cpu_free_wake_mode_en),
        .x1_cpu_sel(link.x1_cpu_sel), .x1_tick(link.x1_tick), .hsosc_en(link.hsosc_en), .mode(link.mode));

    initial forever #12.5 ref_clk = ~ref_clk;

    // Own tick count, cleared whenever the status must clear
    always @(posedge ref_clk) begin
        if (sys_rst || link.x1_osc_stop_ctl || (link.stop_req && link.mode == ST_RUN)) ticks <= 0;
        else if (link.x1_tick === 1'b1) ticks <= ticks + 1;
    end

    // ************************************************
    // Helpers
    // ************************************************
    function automatic byte_t status(int t, int sel);
        byte_t r;
        r = 8'h00;
        for (int k = 0; k < 8; k++) begin
            if (k <= sel && t >= (1 << (EXPS[39 - 5 * k -: 5] - CUT))) r[7 - k] = 1'b1;
        end
        return r;
    endfunction : status

    task automatic conclude();
        if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic pause(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask : pause

    task automatic wr(input addr_t a, input byte_t d);
        @(posedge ref_clk);
        sw_wr <= 1'b1;
        sw_addr <= a;
        sw_wdata <= d;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
    endtask : wr

    task automatic rd(input addr_t a, output byte_t d);
        @(posedge ref_clk);
        sw_rd <= 1'b1;
        sw_addr <= a;
        @(posedge ref_clk);
        sw_rd <= 1'b0;
        #1;
        d = sw_rdata;
    endtask : rd

    // Interrupt pin up until the CPU clock returns; bounded
    task automatic wake(output int c);
        @(posedge ref_clk);
        irq_pin <= 1'b1;
        c = 0;
        while (cpu_clk_en !== 1'b1 && c < 2000) begin
            pause(1);
            c++;
        end
        if (c >= 2000) begin
            n_mismatch++;
            conclude();
        end
        @(posedge ref_clk);
        irq_pin <= 1'b0;
        pause(4);
    endtask : wake

    initial begin
        repeat (100000) @(posedge ref_clk);
        n_mismatch++;
        conclude();
    end

    // ************************************************
    // Sequence
    // ************************************************
    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 8; i++) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].d);
            else begin
                rd(rows[i].a, got);
                `CHK(got, rows[i].d)
            end
        end
        // Crystal starts under reset defaults; status fills in order
        for (i = 0; i < 200; i++) begin
            rd(`CNT_STATUS_ADDR, got);
            `CHK(got === status(ticks, 3) || got === status(ticks - 1, 3) || got === status(ticks - 2, 3), 1'b1)
        end
        `CHK(got, 8'hF0)
        wr(`CMD_ADDR, 8'h01);
        pause(2);
        `CHK({cpu_clk_en, hoco_en, loco_en, port_hold}, 4'b0101)
        rd(`STAT_ADDR, got);
        `CHK(got, 8'h19)
        wake(n);
        `CHK(n < 8, 1'b1)
        rd(`CFG_ADDR, got);
        `CHK(got, 8'h01)
        wr(`CMD_ADDR, 8'h02);
        pause(2);
        `CHK({cpu_clk_en, hoco_en, loco_en, port_hold, periph_stop}, 5'b00011)
        rd(`CNT_STATUS_ADDR, got);
        `CHK(got, 8'h00)
        wake(n);
        `CHK(n >= 200, 1'b1)
        rd(`CNT_STATUS_ADDR, got);
        `CHK(got, 8'hF0)
        wr(`CFG_ADDR, 8'h02);
        wr(`CMD_ADDR, 8'h02);
        pause(2);
        `CHK(periph_stop, 1'b0)
        for (i = 0; i < 2; i++) begin
            @(posedge ref_clk);
            if (i == 0) rx_pin <= 1'b1;
            else adc_pin <= 1'b1;
            pause(4);
            `CHK({cpu_free_wake_mode_run, cpu_clk_en, link.mode}, {2'b10, ST_CPU_FREE_WAKE_MODE})
            @(posedge ref_clk);
            rx_pin <= 1'b0;
            adc_pin <= 1'b0;
            done_pin <= 1'b1;
            pause(4);
            `CHK(link.mode, ST_STOP)
            @(posedge ref_clk);
            done_pin <= 1'b0;
            pause(3);
        end
        wake(n);
        `CHK(n < 8, 1'b1)
        // Cpu_free_wake_mode asked for while the crystal clocks the CPU
        wr(`CFG_ADDR, 8'h07);
        wr(`CMD_ADDR, 8'h02);
        @(posedge ref_clk);
        rx_pin <= 1'b1;
        pause(5);
        `CHK({link.mode, loco_en}, {ST_STOP, 1'b1})
        @(posedge ref_clk);
        rx_pin <= 1'b0;
        wake(n);
        wr(`CFG_ADDR, 8'h09);
        rd(`CNT_STATUS_ADDR, got);
        `CHK(got, 8'h00)
        wr(`CFG_ADDR, 8'h01);
        // Reset in the middle of halt
        wr(`CMD_ADDR, 8'h01);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        pause(6);
        `CHK({cpu_clk_en, port_hold, link.mode}, {2'b10, ST_RUN})
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(`TIME_SEL_ADDR, got);
        `CHK(got, 8'h07)
        conclude();
    end
endmodule : tb_standby_and_osc_stabilization

`default_nettype wire

// ---- design/stby_ctl.sv ----
// CPU and oscillator side of the standby link: software command port,
// wake pin synchronisers and a model-free crystal start/tick generator.
// Assumes wake pins are asynchronous and software uses the plain port.
`include "stby_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module stby_ctl
    import stby_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Software port
    input wire logic [19:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [7:0] sw_rdata,
    // Wake pins
    input wire logic irq_pin,
    input wire logic serial_rx_pin,
    input wire logic adc_trig_pin,
    input wire logic cpu_free_wake_mode_done_pin,
    // Peripheral control
    output logic periph_stop,
    // Link to the device
    stby_if.ctl link
);

    // ************************************************
    // Declarations
    // ************************************************
    localparam int START_CYC = `X1_START_CYC;
    localparam int DIV = `X1_DIV;

    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [7:0] cfg_ff;
    logic halt_ff;
    logic stop_ff;
    logic [7:0] rdata_ff;
    logic dev_rd_ff;
    logic periph_stop_ff;
    logic [15:0] start_ff;
    logic x1_run_ff;
    logic [7:0] div_ff;
    logic tick_ff;
    logic own_hit;

    // ************************************************
    // Wake pin synchronisers
    // ************************************************
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
        end else begin
            sync1_ff <= {cpu_free_wake_mode_done_pin, adc_trig_pin, serial_rx_pin, irq_pin};
            sync2_ff <= sync1_ff;
        end
    end

    // ************************************************
    // Command and configuration registers
    // ************************************************
    // cpu_free_wake_mode setup written ahead of stop
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cfg_ff <= `CFG_RESET;
        end else if (sw_wr && (sw_addr == `CFG_ADDR)) begin
            cfg_ff <= sw_wdata;
        end
    end

    // stop only from the main clock
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            halt_ff <= 1'b0;
            stop_ff <= 1'b0;
        end else begin
            halt_ff <= sw_wr && (sw_addr == `CMD_ADDR) && sw_wdata[`CMD_HALT_BIT];
            stop_ff <= sw_wr && (sw_addr == `CMD_ADDR) && sw_wdata[`CMD_STOP_BIT];
        end
    end

    // peripherals and converter off in stop unless cpu_free_wake_mode is enabled
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            periph_stop_ff <= 1'b0;
        end else begin
            periph_stop_ff <= ((link.mode == ST_STOP) | stop_ff) & ~cfg_ff[`CFG_CPU_FREE_WAKE_MODE_BIT];
        end
    end

    // Device registers pass straight through so their read latency stays one cycle
    assign own_hit = (sw_addr == `CMD_ADDR) | (sw_addr == `CFG_ADDR) | (sw_addr == `STAT_ADDR);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_ff <= 8'h00;
            dev_rd_ff <= 1'b0;
        end else begin
            dev_rd_ff <= sw_rd & ~own_hit;
            if (sw_rd && (sw_addr == `CFG_ADDR)) begin
                rdata_ff <= cfg_ff;
            end else if (sw_rd && (sw_addr == `STAT_ADDR)) begin
                rdata_ff <= {3'h0, x1_run_ff, link.hsosc_en, link.mode};
            end else begin
                rdata_ff <= 8'h00;
            end
        end
    end

    // ************************************************
    // Crystal start and tick generation
    // ************************************************
    // Start delay excluded from stabilization by holding x1_run low
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !link.hsosc_en) begin
            start_ff <= 16'h0000;
            x1_run_ff <= 1'b0;
        end else if (start_ff < 16'(START_CYC)) begin
            start_ff <= start_ff + 16'h0001;
        end else begin
            x1_run_ff <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || !x1_run_ff) begin
            div_ff <= 8'h00;
            tick_ff <= 1'b0;
        end else if (div_ff == 8'(DIV - 1)) begin
            div_ff <= 8'h00;
            tick_ff <= 1'b1;
        end else begin
            div_ff <= div_ff + 8'h01;
            tick_ff <= 1'b0;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign sw_rdata = dev_rd_ff ? link.reg_rdata : rdata_ff;
    assign periph_stop = periph_stop_ff;
    assign link.halt_req = halt_ff;
    assign link.stop_req = stop_ff;
    assign link.irq = sync2_ff[0];
    assign link.serial_rx_req = sync2_ff[1];
    assign link.adc_trig = sync2_ff[2];
    assign link.cpu_free_wake_mode_done = sync2_ff[3];
    assign link.x1_cpu_sel = cfg_ff[`CFG_X1_SEL_BIT];
    assign link.cpu_free_wake_mode_en = cfg_ff[`CFG_CPU_FREE_WAKE_MODE_BIT];
    assign link.loco_opt = cfg_ff[`CFG_LOCO_BIT];
    assign link.x1_osc_stop_ctl = cfg_ff[`CFG_XSTOP_BIT];
    assign link.x1_run = x1_run_ff;
    assign link.x1_tick = tick_ff;
    assign link.reg_addr = sw_addr;
    assign link.reg_wdata = sw_wdata;
    assign link.reg_wr = sw_wr & ~own_hit;
    assign link.reg_rd = sw_rd & ~own_hit;

endmodule : stby_ctl

`default_nettype wire

// ---- design/stby_dev.sv ----
// Standby sequencer: halt, stop and cpu_free_wake_mode modes plus the crystal
// stabilization counter with its status and time-select registers.
// Assumes the controller end drives the link on ref_clk.
//
// Operation
// - Halt gates CPU clock, high-speed oscillators keep running
// - Stop halts both high-speed oscillators
// - Interrupt request releases stop mode
// - Stabilization wait after stop when crystal clocks
// - Cpu_free_wake_mode trigger leaves stop without CPU
// - Cpu_free_wake_mode only with on-chip oscillator clock
// - Standby holds registers, memory and ports
// - Stop entered only from main clock
// - Halt peripherals before stop, except cpu_free_wake_mode
// - Program cpu_free_wake_mode setup before entering stop
// - Clear converter start and enable first
// - Low-speed oscillator follows option setting
// - Status register read-only, byte readable
// - Status clears on reset, stop, crystal-stop
// - Status bits fill in order, stay set
// - Bits map to 2^8 through 2^18 cycles
// - Counter stops at selected stabilization time
// - Status usable with on-chip oscillator clocking
// - Count only from crystal oscillation start
// - Select resets to 07H, eight codes
// - Crystal CPU clock waits selected time
`include "stby_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module stby_dev
    import stby_pkg::*;
#(
    // Lowers every threshold exponent to shorten simulation
    parameter int STAB_EXP_CUT = 0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Link to the controller
    stby_if.dev link,
    // Clock gating toward the chip
    output logic cpu_clk_en,
    output logic hoco_en,
    output logic loco_en,
    output logic cpu_free_wake_mode_run,
    output logic port_hold
);

    // ************************************************
    // Declarations
    // ************************************************
    localparam logic [39:0] EXP_TABLE = `STAB_EXP_TABLE;

    stby_state_t state_ff;
    stby_state_t nxt_state;
    logic [`TIME_SEL_MSB:0] tsel_ff;
    logic [18:0] cnt_ff;
    logic [7:0] status_ff;
    logic [7:0] rdata_ff;
    logic hsosc_en_ff;
    logic cpu_clk_en_ff;
    logic hoco_en_ff;
    logic loco_en_ff;
    logic cpu_free_wake_mode_run_ff;
    logic port_hold_ff;
    logic stab_clr;
    logic stab_done;
    logic cpu_free_wake_mode_ok;
    logic cpu_free_wake_mode_trig;
    logic [2:0] sel_bit;
    logic [4:0] sel_exp;
    logic [18:0] cnt_limit;

    // ************************************************
    // Mode sequencer
    // ************************************************
    // cpu_free_wake_mode needs on-chip clock
    assign cpu_free_wake_mode_ok = link.cpu_free_wake_mode_en & ~link.x1_cpu_sel;
    assign cpu_free_wake_mode_trig = link.serial_rx_req | link.adc_trig;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN: begin
                if (link.stop_req) begin
                    nxt_state = ST_STOP;
                end else if (link.halt_req) begin
                    nxt_state = ST_HALT;
                end
            end
            ST_HALT: begin
                if (link.irq) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_STOP: begin
                if (link.irq) begin
                    nxt_state = link.x1_cpu_sel ? ST_WAIT : ST_RUN;
                end else if (cpu_free_wake_mode_ok && cpu_free_wake_mode_trig) begin
                    nxt_state = ST_CPU_FREE_WAKE_MODE;
                end
            end
            ST_CPU_FREE_WAKE_MODE: begin
                if (link.irq) begin
                    nxt_state = ST_RUN;
                end else if (link.cpu_free_wake_mode_done) begin
                    nxt_state = ST_STOP;
                end
            end
            ST_WAIT: begin
                if (stab_done) begin
                    nxt_state = ST_RUN;
                end
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_ff <= ST_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ************************************************
    // Clock and oscillator enables
    // ************************************************
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cpu_clk_en_ff <= 1'b1;
            hsosc_en_ff <= 1'b1;
            hoco_en_ff <= 1'b1;
            loco_en_ff <= 1'b1;
            cpu_free_wake_mode_run_ff <= 1'b0;
            port_hold_ff <= 1'b0;
        end else begin
            // the CPU clock drops in halt, and the low-speed oscillator too unless loco_opt is set
            cpu_clk_en_ff <= (nxt_state == ST_RUN);
            // both high-speed oscillators off in stop
            hsosc_en_ff <= ~link.x1_osc_stop_ctl & (nxt_state != ST_STOP) & (nxt_state != ST_CPU_FREE_WAKE_MODE);
            hoco_en_ff <= (nxt_state != ST_STOP);
            loco_en_ff <= link.loco_opt | (nxt_state == ST_RUN) | (nxt_state == ST_WAIT)
                          | (nxt_state == ST_CPU_FREE_WAKE_MODE);
            cpu_free_wake_mode_run_ff <= (nxt_state == ST_CPU_FREE_WAKE_MODE);
            port_hold_ff <= (nxt_state != ST_RUN);
        end
    end

    // ************************************************
    // Stabilization counter
    // ************************************************
    // clear on stop entry or crystal stop
    assign stab_clr = ((state_ff == ST_RUN) & link.stop_req) | link.x1_osc_stop_ctl;
    assign sel_bit = 3'h7 - tsel_ff;
    assign sel_exp = EXP_TABLE[sel_bit * 5 +: 5] - 5'(STAB_EXP_CUT);
    assign cnt_limit = 19'h00001 << sel_exp;
    assign stab_done = status_ff[sel_bit];

    always_ff @(posedge ref_clk) begin
        if (sys_rst || stab_clr) begin
            cnt_ff <= 19'h00000;
        end else if (link.x1_tick && link.x1_run && (cnt_ff < cnt_limit)) begin
            cnt_ff <= cnt_ff + 19'h00001;
        end
    end

    // sticky bits
    // Clear wins: the count restarts that cycle, so a set from the old count is stale
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_stat
            localparam logic [4:0] EXP_I = EXP_TABLE[gi * 5 +: 5] - 5'(STAB_EXP_CUT);
            always_ff @(posedge ref_clk) begin
                if (sys_rst || stab_clr) begin
                    status_ff[gi] <= 1'b0;
                end else if (cnt_ff >= (19'h00001 << EXP_I)) begin
                    status_ff[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    // ************************************************
    // Register access
    // ************************************************
    // select resets to seven
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tsel_ff <= `TIME_SEL_RESET;
        end else if (link.reg_wr && (link.reg_addr == `TIME_SEL_ADDR)) begin
            tsel_ff <= link.reg_wdata[`TIME_SEL_MSB:0];
        end
    end

    // status readable as a byte, writes ignored
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_ff <= 8'h00;
        end else if (link.reg_rd && (link.reg_addr == `CNT_STATUS_ADDR)) begin
            rdata_ff <= status_ff;
        end else if (link.reg_rd && (link.reg_addr == `TIME_SEL_ADDR)) begin
            rdata_ff <= {5'h00, tsel_ff};
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign link.reg_rdata = rdata_ff;
    assign link.hsosc_en = hsosc_en_ff;
    assign link.mode = state_ff;
    assign cpu_clk_en = cpu_clk_en_ff;
    assign hoco_en = hoco_en_ff;
    assign loco_en = loco_en_ff;
    assign cpu_free_wake_mode_run = cpu_free_wake_mode_run_ff;
    assign port_hold = port_hold_ff;

endmodule : stby_dev

`default_nettype wire

// ---- design/stby_if.sv ----
// Link between the standby device and the CPU/oscillator side.
// Both ends run on ref_clk; no signal here needs a crossing.
`timescale 1ns/1ps
`default_nettype none

interface stby_if;
    import stby_pkg::*;
    // Standby requests and wake sources
    logic halt_req;
    logic stop_req;
    logic irq;
    logic serial_rx_req;
    logic adc_trig;
    logic cpu_free_wake_mode_done;
    // Configuration levels
    logic cpu_free_wake_mode_en;
    logic x1_cpu_sel;
    logic x1_osc_stop_ctl;
    logic loco_opt;
    // Crystal oscillator state and standby mode
    logic x1_run;
    logic x1_tick;
    logic hsosc_en;
    stby_state_t mode;
    // Register access
    addr_t reg_addr;
    byte_t reg_wdata;
    logic reg_wr;
    logic reg_rd;
    byte_t reg_rdata;

    modport dev (
        input halt_req, stop_req, irq, serial_rx_req, adc_trig, cpu_free_wake_mode_done,
        input cpu_free_wake_mode_en, x1_cpu_sel, x1_osc_stop_ctl, loco_opt, x1_run, x1_tick,
        input reg_addr, reg_wdata, reg_wr, reg_rd,
        output hsosc_en, mode, reg_rdata
    );
    modport ctl (
        output halt_req, stop_req, irq, serial_rx_req, adc_trig, cpu_free_wake_mode_done,
        output cpu_free_wake_mode_en, x1_cpu_sel, x1_osc_stop_ctl, loco_opt, x1_run, x1_tick,
        output reg_addr, reg_wdata, reg_wr, reg_rd,
        input hsosc_en, mode, reg_rdata
    );
endinterface : stby_if

`default_nettype wire

// ---- design/stby_pkg.sv ----
// Types shared by the standby device and its controller.
// Assumes stby_regs.svh supplies the numeric constants.
package stby_pkg;

    // Gray codes along run, halt, stop, wait, cpu_free_wake_mode
    typedef enum logic [2:0] {
        ST_RUN    = 3'h0,
        ST_HALT   = 3'h1,
        ST_STOP   = 3'h3,
        ST_WAIT   = 3'h2,
        ST_CPU_FREE_WAKE_MODE = 3'h6
    } stby_state_t;

    typedef logic [7:0] byte_t;
    typedef logic [19:0] addr_t;

endpackage : stby_pkg

// ---- design/stby_regs.svh ----
// Offsets, field positions, reset values and timing counts of the standby block.
// Included by both ends; it holds definitions only.
`ifndef STBY_REGS_SVH
`define STBY_REGS_SVH

// ************************************************
// Device register addresses and reset values
// ************************************************
`define CNT_STATUS_ADDR 20'hFFFA2
`define TIME_SEL_ADDR 20'hFFFA3
`define CNT_STATUS_RESET 8'h00
`define TIME_SEL_RESET 3'h7
`define TIME_SEL_MSB 2

// Threshold exponents, status bit 7 first (2^8) down to bit 0 (2^18)
`define STAB_EXP_TABLE {5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0D, 5'h0F, 5'h11, 5'h12}

// ************************************************
// Controller registers
// ************************************************
`define CMD_ADDR 20'h00000
`define CFG_ADDR 20'h00001
`define STAT_ADDR 20'h00002
`define CMD_HALT_BIT 0
`define CMD_STOP_BIT 1
`define CFG_X1_SEL_BIT 0
`define CFG_CPU_FREE_WAKE_MODE_BIT 1
`define CFG_LOCO_BIT 2
`define CFG_XSTOP_BIT 3
`define CFG_RESET 8'h01

// ************************************************
// Timing
// ************************************************
`define REF_FREQ_MHZ 40
`define X1_FREQ_MHZ 10
`define X1_DIV (`REF_FREQ_MHZ / `X1_FREQ_MHZ)
`define X1_START_NS 2000
`define X1_START_CYC ((`X1_START_NS * `REF_FREQ_MHZ + 999) / 1000)

`endif
